// >>> logic/rcch_pkg.sv
package rcch_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_VAR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ERROR = 8'h0c;
    localparam logic [7:0] OFS_OBUF = 8'h10;
    localparam logic [7:0] OFS_MSG_WR = 8'h14;
    localparam logic [7:0] OFS_MSG_RD = 8'h40;
    localparam logic [7:0] OFS_MSG_RD_END = 8'h7c;

    // ------------------------------------------------------------
    // Reset values and message size
    // ------------------------------------------------------------
    localparam int MSG_LEN = 16;
    localparam logic [31:0] RST_VAR = 32'h0000_0000;
    localparam logic [7:0] RST_SRQ_MASK = 8'h00;
    localparam logic [2:0] RST_FUNC = 3'h1;
    localparam logic [3:0] RST_RANGE = 4'h1;
    localparam logic [1:0] RST_RATE = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint STORE_MAX_S = 22;
    localparam longint ERASE_MAX_S = 3;
    localparam logic [31:0] STORE_MAX_CYC = 32'(STORE_MAX_S * CLK_HZ);
    localparam logic [31:0] ERASE_MAX_CYC = 32'(ERASE_MAX_S * CLK_HZ);

    // ------------------------------------------------------------
    // Commands, phases, jobs
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_GET_PROMPT = 4'h0, OP_FUNCTION = 4'h1, OP_RANGE = 4'h2, OP_AUTORANGE = 4'h3,
        OP_STORE = 4'h4, OP_ADC_SEL = 4'h5, OP_HF_SEL = 4'h6, OP_ERASE = 4'h7,
        OP_RATE = 4'h8, OP_VAR_IN = 4'h9, OP_STORE_MSG = 4'ha, OP_MSG_READ = 4'hb,
        OP_SRQ_MASK = 4'hc, OP_ERR_CLEAR = 4'hd, OP_OTHER_GET = 4'he, OP_RSVD = 4'hf
    } rcch_op_t;

    typedef enum logic [2:0] {
        PH_NORMAL = 3'b000, PH_ADC = 3'b001, PH_OG = 3'b010, PH_HF = 3'b011,
        PH_VERIFY = 3'b100
    } rcch_phase_t;

    typedef enum logic [2:0] {
        JOB_STORE = 3'b000, JOB_ERASE_ALL = 3'b001, JOB_SEL_ADC = 3'b010,
        JOB_SEL_OG = 3'b011, JOB_SEL_HF = 3'b100, JOB_RATE = 3'b101
    } rcch_job_t;

    typedef enum logic [1:0] {
        OB_PROMPT = 2'b00, OB_ERROR = 2'b01, OB_MESSAGE = 2'b10, OB_DATA = 2'b11
    } rcch_obuf_t;

    typedef struct packed {
        logic [7:0] arg;
        rcch_op_t op;
    } rcch_cmd_t;

    typedef struct packed {
        logic start;
        rcch_job_t job;
        logic [2:0] func;
        logic [3:0] range;
        logic [1:0] rate;
    } rcch_mp_t;

    // Error register bit positions.
    localparam int ERR_INVALID = 0;
    localparam int ERR_OVERRUN = 1;
    localparam int ERR_TIMEOUT = 2;
    localparam int ERR_W = 3;

    // Status bit positions.
    localparam int ST_STEP_DONE = 0;
    localparam int ST_ERASE_PEND = 1;
    localparam int ST_CAL_MODE = 2;
    localparam int ST_SRQ = 3;
    localparam int ST_PHASE = 4;
    localparam int SRQ_BIT_STEP = 0;

endpackage

// >>> logic/rcch_msg_store.sv
`timescale 1ns/1ps
module rcch_msg_store #(
    parameter int LEN = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_stage_we,
    input wire logic [$clog2(LEN)-1:0] i_stage_idx,
    input wire logic [7:0] i_stage_char,
    input wire logic i_commit,
    input wire logic [$clog2(LEN)-1:0] i_rd_idx,
    output logic [7:0] o_rd_char
);
    logic [7:0] stage [LEN];
    logic [7:0] saved [LEN];
    logic [7:0] next_stage [LEN];
    logic [7:0] next_saved [LEN];

    always_comb begin
        next_stage = stage;
        next_saved = saved;
        if (i_stage_we) begin
            next_stage[i_stage_idx] = i_stage_char;
        end
        if (i_commit) begin
            next_saved = stage;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < LEN; i++) begin
                stage[i] <= 8'h20;
                saved[i] <= 8'h20;
            end
        end else begin
            stage <= next_stage;
            saved <= next_saved;
        end
    end

    assign o_rd_char = saved[i_rd_idx];
endmodule // rcch_msg_store

// >>> logic/rcch_top.sv
`timescale 1ns/1ps
// Functional notes
// RL1 - Get-prompt loads prompt; invalid while verifying.
// RL2 - Function select starts offset/gain for function.
// RL3 - Ranges 1-6,8 start offset/gain calibration.
// RL4 - Store accepts input, measures, saves constants.
// RL5 - Store lasts up to 22 s.
// RL6 - A/D select enters converter calibration.
// RL7 - HF select enters high-frequency AC calibration.
// RL8 - Erase shows clear prompt, not buffered.
// RL9 - Erase then store clears all; no timeout.
// RL10 - Other command after erase aborts it.
// RL11 - Rate valid only while verifying, else error.
// RL12 - Variable input errors in A/D or verify.
// RL13 - Store and read back 16-char message.
// RL14 - Autorange and similar load an error message.
// RL15 - Sample-complete inactive during calibration.
// RL16 - Sample-complete normal while verifying.
// RL17 - Mask write, readbacks, error clear accepted.
// RL18 - Step-done clears on dispatch, sets on finish.
// RL19 - Masked service request on step completion.
// RL20 - Full erase lasts up to 3 s.
// RL21 - One command at a time, phase checked.
module rcch_top
    import rcch_pkg::*;
#(
    parameter logic [31:0] STORE_MAX = rcch_pkg::STORE_MAX_CYC,
    parameter logic [31:0] ERASE_MAX = rcch_pkg::ERASE_MAX_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [rcch_pkg::ADDR_W-1:0] i_addr,
    input wire logic [rcch_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [rcch_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_cal_enable,
    output rcch_pkg::rcch_mp_t o_mp,
    input wire logic i_mp_done,
    input wire logic i_mp_proc_done,
    input wire logic i_sample_done,
    output logic o_sample_complete,
    output logic o_disp_clear_prompt,
    output logic o_srq
);
    import rcch_pkg::*;

    // ------------------------------------------------------------
    // Reset release and switch synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] cal_sync;
    logic cal_mode;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_sync <= 3'b000;
            cal_mode <= 1'b0;
        end else begin
            cal_sync <= {cal_sync[1:0], i_cal_enable};
            if (cal_sync[2] == cal_sync[1]) begin
                cal_mode <= cal_sync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic is_msg_addr(input logic [ADDR_W-1:0] a);
        return (a >= OFS_MSG_RD) && (a <= OFS_MSG_RD_END) && (a[1:0] == 2'b00);
    endfunction

    rcch_cmd_t cmd;
    logic cmd_wr;
    assign cmd = rcch_cmd_t'(i_wdata[11:0]);
    assign cmd_wr = i_we && (i_addr == OFS_CMD);

    // ------------------------------------------------------------
    // Command state
    // ------------------------------------------------------------
    rcch_phase_t phase, next_phase;
    logic [2:0] func, next_func;
    logic [3:0] range, next_range;
    logic [1:0] rate, next_rate;
    logic [31:0] var_in, next_var_in;
    logic [7:0] srq_mask, next_srq_mask;
    logic [ERR_W-1:0] err, next_err;
    logic step_done, next_step_done;
    logic erase_pend, next_erase_pend;
    logic srq, next_srq;
    logic ob_valid, next_ob_valid;
    rcch_obuf_t ob_kind, next_ob_kind;
    logic [15:0] ob_data, next_ob_data;
    rcch_mp_t mp, next_mp;
    logic [31:0] wdog, next_wdog;
    logic msg_commit;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [7:0] msg_char;

    always_comb begin
        next_phase = phase;
        next_func = func;
        next_range = range;
        next_rate = rate;
        next_var_in = var_in;
        next_srq_mask = srq_mask;
        next_err = err;
        next_step_done = step_done;
        next_erase_pend = erase_pend;
        next_srq = srq;
        next_ob_valid = ob_valid;
        next_ob_kind = ob_kind;
        next_ob_data = ob_data;
        next_mp = mp;
        next_mp.start = 1'b0;
        next_wdog = wdog;
        msg_commit = 1'b0;

        // Reading the output buffer or status empties it or drops the request.
        if (i_re && (i_addr == OFS_OBUF)) begin
            next_ob_valid = 1'b0;
        end
        if (i_re && (i_addr == OFS_STATUS)) begin
            next_srq = 1'b0;
        end
        if (i_we && (i_addr == OFS_VAR)) begin
            next_var_in = i_wdata;
        end
        if (!cal_mode) begin
            next_phase = PH_NORMAL;
            next_erase_pend = 1'b0;
        // RL15 calibration opens at A/D
        end else if (phase == PH_NORMAL) begin
            next_phase = PH_ADC;
        end

        // Completion of the job handed to the measurement processor.
        if (!step_done) begin
            next_wdog = wdog + 32'h1;
            // RL18 RL19 step completion
            if (i_mp_done) begin
                next_step_done = 1'b1;
                next_wdog = 32'h0;
                if (srq_mask[SRQ_BIT_STEP]) begin
                    next_srq = 1'b1;
                end
                // RL9 erase reenters A/D
                if (mp.job == JOB_ERASE_ALL) begin
                    next_phase = PH_ADC;
                end else if (mp.job == JOB_STORE && i_mp_proc_done) begin
                    next_phase = PH_VERIFY;
                end
            // RL5 RL20 job time limits
            end else if ((mp.job == JOB_ERASE_ALL && wdog >= ERASE_MAX) ||
                         (mp.job != JOB_ERASE_ALL && wdog >= STORE_MAX)) begin
                next_step_done = 1'b1;
                next_wdog = 32'h0;
                next_err[ERR_TIMEOUT] = 1'b1;
            end
        end

        // RL21 one command at a time
        if (cmd_wr && !step_done) begin
            next_err[ERR_OVERRUN] = 1'b1;
        end else if (cmd_wr && erase_pend && cmd.op != OP_STORE) begin
            // RL10 abort pending erase
            next_erase_pend = 1'b0;
        end else if (cmd_wr) begin
            unique case (cmd.op)
                OP_GET_PROMPT: begin
                    // RL1 prompt or error
                    if (phase == PH_VERIFY || phase == PH_NORMAL) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_ob_valid = 1'b1;
                        next_ob_kind = OB_PROMPT;
                        next_ob_data = {4'h0, phase, func, range, rate};
                    end
                end
                OP_FUNCTION: begin
                    // RL2 function selects procedure
                    if (phase == PH_NORMAL || cmd.arg < 8'h1 || cmd.arg > 8'h6) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_func = cmd.arg[2:0];
                        next_range = RST_RANGE;
                        next_phase = PH_OG;
                        next_mp.job = JOB_SEL_OG;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    end
                end
                OP_RANGE: begin
                    // RL3 range selects procedure
                    if (phase == PH_NORMAL || cmd.arg < 8'h1 || cmd.arg == 8'h7 ||
                        cmd.arg > 8'h8) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_range = cmd.arg[3:0];
                        next_phase = PH_OG;
                        next_mp.job = JOB_SEL_OG;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    end
                end
                OP_STORE: begin
                    // RL9 full erase on store
                    if (erase_pend) begin
                        next_erase_pend = 1'b0;
                        next_mp.job = JOB_ERASE_ALL;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    // RL4 store accepts input
                    end else if (phase == PH_NORMAL || phase == PH_VERIFY) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_mp.job = JOB_STORE;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    end
                end
                OP_ADC_SEL, OP_HF_SEL: begin
                    // RL6 RL7 procedure select
                    if (phase == PH_NORMAL) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_phase = (cmd.op == OP_ADC_SEL) ? PH_ADC : PH_HF;
                        next_mp.job = (cmd.op == OP_ADC_SEL) ? JOB_SEL_ADC : JOB_SEL_HF;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    end
                end
                OP_ERASE: begin
                    // RL8 clear prompt pending
                    if (phase == PH_NORMAL) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_erase_pend = 1'b1;
                    end
                end
                OP_RATE: begin
                    // RL11 rate only verifying
                    if (phase != PH_VERIFY || cmd.arg > 8'h2) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_rate = cmd.arg[1:0];
                        next_mp.job = JOB_RATE;
                        next_mp.start = 1'b1;
                        next_step_done = 1'b0;
                    end
                end
                OP_VAR_IN: begin
                    // RL12 variable input check
                    if (phase == PH_ADC || phase == PH_VERIFY || phase == PH_NORMAL) begin
                        next_err[ERR_INVALID] = 1'b1;
                    end else begin
                        next_ob_data = var_in[15:0];
                    end
                end
                OP_STORE_MSG: begin
                    // RL13 commit message
                    msg_commit = 1'b1;
                end
                OP_MSG_READ: begin
                    // RL13 message readback
                    next_ob_valid = 1'b1;
                    next_ob_kind = OB_MESSAGE;
                    next_ob_data = 16'(MSG_LEN);
                end
                OP_AUTORANGE, OP_RSVD: begin
                    // RL14 error into buffer
                    next_err[ERR_INVALID] = 1'b1;
                    next_ob_valid = 1'b1;
                    next_ob_kind = OB_ERROR;
                    next_ob_data = {12'h0, 4'(cmd.op)};
                end
                OP_SRQ_MASK: begin
                    // RL17 mask write accepted
                    next_srq_mask = cmd.arg;
                end
                OP_ERR_CLEAR: begin
                    // RL17 error clear accepted
                    next_err = '0;
                end
                OP_OTHER_GET: begin
                    // RL17 readback accepted
                    next_ob_valid = 1'b1;
                    next_ob_kind = OB_DATA;
                    next_ob_data = {5'h0, func, range, rate, 2'b00};
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (i_re) begin
            if (i_addr == OFS_VAR) begin
                next_rdata = var_in;
            end else if (i_addr == OFS_STATUS) begin
                next_rdata = {25'h0, phase, srq, cal_mode, erase_pend, step_done};
            end else if (i_addr == OFS_ERROR) begin
                next_rdata = {29'h0, err};
            end else if (i_addr == OFS_OBUF) begin
                next_rdata = {13'h0, ob_valid, ob_kind, ob_data};
            end else if (is_msg_addr(i_addr)) begin
                next_rdata = {24'h0, msg_char};
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_NORMAL;
            func <= RST_FUNC;
            range <= RST_RANGE;
            rate <= RST_RATE;
            var_in <= RST_VAR;
            srq_mask <= RST_SRQ_MASK;
            err <= '0;
            step_done <= 1'b1;
            erase_pend <= 1'b0;
            srq <= 1'b0;
            ob_valid <= 1'b0;
            ob_kind <= OB_PROMPT;
            ob_data <= 16'h0;
            mp <= '0;
            wdog <= 32'h0;
            rdata <= '0;
        end else begin
            phase <= next_phase;
            func <= next_func;
            range <= next_range;
            rate <= next_rate;
            var_in <= next_var_in;
            srq_mask <= next_srq_mask;
            err <= next_err;
            step_done <= next_step_done;
            erase_pend <= next_erase_pend;
            srq <= next_srq;
            ob_valid <= next_ob_valid;
            ob_kind <= next_ob_kind;
            ob_data <= next_ob_data;
            mp <= '{start: next_mp.start, job: next_mp.job, func: next_func,
                    range: next_range, rate: next_rate};
            wdog <= next_wdog;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Message memory
    // ------------------------------------------------------------
    rcch_msg_store #(
        .LEN(MSG_LEN)
    ) u_msg (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_stage_we(i_we && (i_addr == OFS_MSG_WR)),
        .i_stage_idx(i_wdata[11:8]),
        .i_stage_char(i_wdata[7:0]),
        .i_commit(msg_commit),
        .i_rd_idx(i_addr[5:2]),
        .o_rd_char(msg_char)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata;
    assign o_mp = mp;
    assign o_srq = srq;
    assign o_disp_clear_prompt = erase_pend;
    // RL15 RL16 sample-complete gating
    assign o_sample_complete = i_sample_done && (phase == PH_NORMAL || phase == PH_VERIFY);
endmodule // rcch_top

// >>> tb/rcch_chk.sv
`timescale 1ns/1ps
module rcch_chk
    import rcch_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [rcch_pkg::ADDR_W-1:0] i_addr,
    input wire logic [rcch_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [rcch_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_cal_enable,
    input wire rcch_pkg::rcch_mp_t o_mp,
    input wire logic i_mp_done,
    input wire logic i_sample_done,
    input wire logic o_sample_complete,
    input wire logic o_disp_clear_prompt,
    input wire logic o_srq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire cmd_wr = i_we && (i_addr == OFS_CMD);
    wire erase_wr = cmd_wr && (i_wdata[3:0] == 4'h7);
    wire store_wr = cmd_wr && (i_wdata[3:0] == 4'h4);
    // Switch held off long enough for the synchroniser to settle.
    sequence cal_off;
        !i_cal_enable [*8];
    endsequence
    chk_start_one_cycle: assert property (o_mp.start |=> !o_mp.start)
        else $error("job start longer than one cycle");
    chk_start_from_cmd: assert property (o_mp.start |-> $past(cmd_wr))
        else $error("job start without a command write");
    chk_rdata_idle: assert property (!$past(i_re) |-> o_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    chk_srq_cause: assert property ($rose(o_srq) |-> $past(i_mp_done))
        else $error("service request without job completion");
    chk_prompt_cause: assert property ($rose(o_disp_clear_prompt) |-> $past(erase_wr))
        else $error("clear prompt without erase command");
    chk_erase_abort: assert property (o_disp_clear_prompt && cmd_wr && !store_wr && !erase_wr
        |=> !o_disp_clear_prompt)
        else $error("erase not abandoned");
    chk_erase_go: assert property (o_disp_clear_prompt && store_wr
        |=> o_mp.start && o_mp.job == JOB_ERASE_ALL)
        else $error("erase then store gave no full erase");
    chk_idle_sample: assert property (cal_off |-> o_sample_complete == i_sample_done)
        else $error("sample complete differs in normal operation");
    chk_idle_nojob: assert property (cal_off |-> !o_mp.start)
        else $error("job started outside calibration");
    chk_sample_gate: assert property (o_sample_complete |-> i_sample_done)
        else $error("sample complete without a sample");
endmodule // rcch_chk

// >>> tb/rcch_mp_model.sv
`timescale 1ns/1ps
module rcch_mp_model
    import rcch_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire rcch_pkg::rcch_mp_t i_mp,
    input wire logic i_slow,
    input wire logic i_proc,
    output logic o_done,
    output logic o_proc_done
);
    int cnt;
    // finish each job after a short or long delay.
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 0;
            o_done <= 1'b0;
            o_proc_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_proc_done <= 1'b0;
            if (i_mp.start) begin
                cnt <= i_slow ? 40 : 3;
            end else if (cnt == 1) begin
                cnt <= 0;
                o_done <= 1'b1;
                o_proc_done <= i_proc && (i_mp.job == JOB_STORE);
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // rcch_mp_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rcch_pkg::*;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_we = 1'b0, i_re = 1'b0;
    logic i_cal_enable = 1'b0, i_sample_done = 1'b0, slow = 1'b0, proc = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, v;
    logic mp_done, mp_proc_done, o_sample_complete, o_disp_clear_prompt, o_srq;
    rcch_mp_t o_mp;
    rcch_job_t last_job;
    int num_errors = 0;
    int checks = 0;
    initial forever #5 i_clk = ~i_clk;
    rcch_top #(.STORE_MAX(32'd200), .ERASE_MAX(32'd50)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
        .i_cal_enable(i_cal_enable), .o_mp(o_mp), .i_mp_done(mp_done),
        .i_mp_proc_done(mp_proc_done), .i_sample_done(i_sample_done),
        .o_sample_complete(o_sample_complete), .o_disp_clear_prompt(o_disp_clear_prompt),
        .o_srq(o_srq));
    rcch_mp_model u_mp (.i_clk(i_clk), .i_nrst(i_nrst), .i_mp(o_mp), .i_slow(slow),
        .i_proc(proc), .o_done(mp_done), .o_proc_done(mp_proc_done));
    always @(posedge i_clk) if (o_mp.start) last_job <= o_mp.job;
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
        wr(OFS_CMD, {20'h0, arg, op});
        for (int i = 0; i < 100; i++) begin
            rd(OFS_STATUS);
            if (v[0] === 1'b1) break;
        end
        chk(v[0], 1'b1);
    endtask
    task automatic err_is(input logic [2:0] e);
        rd(OFS_ERROR);
        chk(v[2:0], e);
        cmd(4'hd, 8'h00);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        rd(OFS_STATUS);
        chk(v[6:0], 7'h01);
        rd(8'h30);
        chk(v, 32'h0);
        cmd(4'h1, 8'h02);
        err_is(3'h1);
        err_is(3'h0);
        i_cal_enable <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic t_adc_hf_og();
        cmd(4'h5, 8'h00);
        chk(last_job, JOB_SEL_ADC);
        cmd(4'h9, 8'h00);
        err_is(3'h1);
        cmd(4'h8, 8'h01);
        err_is(3'h1);
        cmd(4'h3, 8'h00);
        rd(OFS_OBUF);
        chk(v[18:16], 3'b101);
        err_is(3'h1);
        cmd(4'h0, 8'h00);
        rd(OFS_OBUF);
        chk(v[18:16], 3'b100);
        cmd(4'h6, 8'h00);
        chk(last_job, JOB_SEL_HF);
        wr(OFS_VAR, 32'h0000_1234);
        cmd(4'h9, 8'h00);
        err_is(3'h0);
        cmd(4'h1, 8'h03);
        chk({o_mp.job, o_mp.func}, {JOB_SEL_OG, 3'h3});
        cmd(4'h2, 8'h08);
        chk(o_mp.range, 4'h8);
        i_sample_done <= 1'b1;
        @(posedge i_clk);
        #1 chk(o_sample_complete, 1'b0);
    endtask
    task automatic t_store_verify();
        cmd(4'hc, 8'h01);
        slow <= 1'b1;
        proc <= 1'b1;
        wr(OFS_CMD, 32'h4);
        rd(OFS_STATUS);
        chk(v[0], 1'b0);
        wr(OFS_CMD, 32'h5);
        for (int i = 0; i < 200 && o_srq !== 1'b1; i++) @(posedge i_clk);
        chk(o_srq, 1'b1);
        chk(last_job, JOB_STORE);
        rd(OFS_STATUS);
        chk(v[6:0], 7'h4d);
        chk(o_srq, 1'b0);
        err_is(3'h2);
        slow <= 1'b0;
        chk(o_sample_complete, 1'b1);
        cmd(4'h0, 8'h00);
        err_is(3'h1);
        cmd(4'h8, 8'h02);
        chk({o_mp.job, o_mp.rate}, {JOB_RATE, 2'h2});
        cmd(4'h9, 8'h00);
        err_is(3'h1);
    endtask
    task automatic t_erase_msg();
        cmd(4'h7, 8'h00);
        chk(o_disp_clear_prompt, 1'b1);
        rd(OFS_OBUF);
        chk(v[18], 1'b0);
        cmd(4'h6, 8'h00);
        chk(o_disp_clear_prompt, 1'b0);
        chk(last_job, JOB_RATE);
        cmd(4'h7, 8'h00);
        repeat (100) @(posedge i_clk);
        chk(o_disp_clear_prompt, 1'b1);
        slow <= 1'b1;
        cmd(4'h4, 8'h00);
        chk(last_job, JOB_ERASE_ALL);
        rd(OFS_STATUS);
        chk(v[6:4], PH_ADC);
        for (int i = 0; i < 16; i++) wr(OFS_MSG_WR, {20'h0, 4'(i), 8'(8'h41 + i)});
        cmd(4'ha, 8'h00);
        for (int i = 0; i < 16; i++) begin
            rd(8'(8'h40 + 4 * i));
            chk(v[7:0], 8'(8'h41 + i));
        end
        cmd(4'hb, 8'h00);
        rd(OFS_OBUF);
        chk(v[18:0], 19'h6_0010);
        cmd(4'he, 8'h00);
        rd(OFS_OBUF);
        chk(v[18:16], 3'b111);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_idle();
        t_adc_hf_og();
        t_store_verify();
        t_erase_msg();
        tally_and_finish();
    end
endmodule // tb_top
bind rcch_top rcch_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
    .i_cal_enable(i_cal_enable), .o_mp(o_mp), .i_mp_done(i_mp_done),
    .i_sample_done(i_sample_done), .o_sample_complete(o_sample_complete),
    .o_disp_clear_prompt(o_disp_clear_prompt), .o_srq(o_srq));
